//--- src/asc_regs.vh
// register map, field positions, reset values and timing counts of the converter sequencer
`ifndef ASC_REGS_VH
`define ASC_REGS_VH
`define ASC_MODE_OFF        12'h000
`define ASC_MODE1_OFF       12'h004
`define ASC_CHAN_OFF        12'h008
`define ASC_PORTCFG_OFF     12'h00C
`define ASC_REFCTL_OFF      12'h010
`define ASC_RESULT_OFF      12'h014
`define ASC_RESULTH_OFF     12'h018
`define ASC_STATUS_OFF      12'h01C
`define ASC_MASK_OFF        12'h020
`define ASC_PERIPH_OFF      12'h024
// converter_mode_reg fields
`define ASC_MODE_START      7
`define ASC_MODE_SCM        6
`define ASC_MODE_FR_HI      5
`define ASC_MODE_FR_LO      3
`define ASC_MODE_LV1        2
`define ASC_MODE_LV0        1
`define ASC_MODE_ENABLE     0
// mode register 1 fields
`define ASC_MODE1_TMD       7
`define ASC_MODE1_TRS       0
// peripheral_enable_reg field
`define ASC_PERIPH_CLKGATE  5
// ref_voltage_ctrl_reg fields
`define ASC_REF_GATE        1
`define ASC_REF_ON          0
// status fields
`define ASC_ST_DONE         0
`define ASC_ST_ABORT        1
`define ASC_ST_BITS         2
`define ASC_RESET_VAL       8'h00
// timing: first conversion after start takes extra stabilisation cycles
`define ASC_FIRST_EXTRA_NS  500
`define ASC_CLK_NS          5
// extra ns rounded up to whole clocks; sized so it adds cleanly to a 16-bit count
`define ASC_FIRST_EXTRA_CYC 16'd100
// base conversion cycles at conv_time_field code 0; each code step doubles the count
`define ASC_CONV_BASE_CYC   64
`endif

//--- src/asc_result_mem.v
// result holding register pair with deferred write when a read collides
`timescale 1ns/1ps
module asc_result_mem #(
  parameter DW = 12
) (
  // clock and reset
  input  wire          pclk,
  input  wire          presetn,
  // write side
  input  wire          wr_en,
  input  wire [DW-1:0] wr_data,
  input  wire          rd_busy,
  // read side
  output reg  [DW-1:0] rd_data
);
  reg          pend;
  reg [DW-1:0] pend_data;

  // a read in progress holds off the store until rd_busy drops so the old value is served
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_data   <= {DW{1'b0}};
      pend      <= 1'b0;
      pend_data <= {DW{1'b0}};
    end
    else if (wr_en && rd_busy)
    begin
      pend      <= 1'b1;
      pend_data <= wr_data;
    end
    else if (wr_en)
    begin
      rd_data <= wr_data;
      pend    <= 1'b0;
    end
    else if (pend && !rd_busy)
    begin
      rd_data <= pend_data;
      pend    <= 1'b0;
    end
  end
endmodule

//--- src/asc_seq.v
// converter sequencing control with apb register file and done interrupt
`timescale 1ns/1ps
`include "asc_regs.vh"
module asc_seq #(
  parameter DW = 12
) (
  // apb
  input  wire          pclk,
  input  wire          presetn,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [11:0]   paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output wire          pready,
  output wire          pslverr,
  // analog core and timer
  input  wire          timer_trig,
  input  wire [DW-1:0] core_data,
  output wire          core_sample,
  output wire [3:0]    core_channel,
  output wire          core_enable,
  // interrupt
  output wire          conversion_done_irq
);
  localparam S_IDLE = 2'd0;
  localparam S_CONV = 2'd1;

  reg [7:0]  converter_mode_reg;
  reg [7:0]  mode1_reg;
  reg [3:0]  channel_select_field;
  reg [4:0]  port_config_reg;
  reg [7:0]  ref_voltage_ctrl_reg;
  reg [7:0]  peripheral_enable_reg;
  reg [`ASC_ST_BITS-1:0] status;
  reg [`ASC_ST_BITS-1:0] mask;
  reg [1:0]  state;
  reg [15:0] cnt;
  reg [3:0]  active_ch;
  reg        first_conv;
  wire [DW-1:0] result_q;

  wire wr  = psel && penable && pwrite;
  wire rd  = psel && penable && !pwrite;
  wire gate = peripheral_enable_reg[`ASC_PERIPH_CLKGATE];
  wire start_bit = converter_mode_reg[`ASC_MODE_START];
  wire single = converter_mode_reg[`ASC_MODE_SCM];
  wire tmd = mode1_reg[`ASC_MODE1_TMD];

  function hit;
    input [11:0] a;
    input [11:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // conversion length from time code and voltage mode
  function [15:0] conv_len;
    input [2:0] fr;
    input [1:0] lv;
    begin
      conv_len = (16'd`ASC_CONV_BASE_CYC << fr) + {12'd0, lv, 2'd0};
    end
  endfunction

  wire w_mode  = wr && gate && hit(paddr, `ASC_MODE_OFF);
  wire w_mode1 = wr && gate && hit(paddr, `ASC_MODE1_OFF);
  wire w_chan  = wr && gate && hit(paddr, `ASC_CHAN_OFF);
  wire w_port  = wr && gate && hit(paddr, `ASC_PORTCFG_OFF);
  wire ctl_wr  = w_mode || w_chan || w_port;
  wire rd_res  = rd && (hit(paddr, `ASC_RESULT_OFF) || hit(paddr, `ASC_RESULTH_OFF));

  wire [15:0] len = conv_len(converter_mode_reg[`ASC_MODE_FR_HI:`ASC_MODE_FR_LO],
                    {converter_mode_reg[`ASC_MODE_LV1], converter_mode_reg[`ASC_MODE_LV0]});
  wire finishing = (state == S_CONV) && (cnt == 16'd1);
  wire done_ok   = finishing && !ctl_wr;
  wire new_start = w_mode && pwdata[`ASC_MODE_START];
  wire chan_abort = w_chan && !(tmd && single);
  wire trig_go    = tmd && timer_trig && gate;

  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign core_sample  = (state == S_CONV);
  assign core_channel = active_ch;
  assign core_enable  = converter_mode_reg[`ASC_MODE_ENABLE];
  assign conversion_done_irq = |(status & mask);

  // sequencer
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state      <= S_IDLE;
      cnt        <= 16'h0000;
      active_ch  <= 4'h0;
      first_conv <= 1'b0;
    end
    else if (!gate || (w_mode && !pwdata[`ASC_MODE_START]))
    begin
      state <= S_IDLE;
      cnt   <= 16'h0000;
    end
    else
    begin
      case (state)
        S_IDLE:
        begin
          if (new_start || trig_go)
          begin
            state      <= S_CONV;
            active_ch  <= channel_select_field;
            first_conv <= 1'b1;
            cnt        <= len + `ASC_FIRST_EXTRA_CYC;
          end
        end
        S_CONV:
        begin
          if (new_start || trig_go)
          begin
            active_ch <= channel_select_field;
            cnt       <= len + `ASC_FIRST_EXTRA_CYC;
          end
          else if (chan_abort)
          begin
            active_ch  <= pwdata[3:0];
            first_conv <= 1'b0;
            cnt        <= len;
          end
          else if (finishing)
          begin
            first_conv <= 1'b0;
            if (single)
              state <= S_IDLE;
            else
            begin
              active_ch <= channel_select_field;
              cnt       <= len;
            end
          end
          else
            cnt <= cnt - 16'd1;
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end

  // registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      converter_mode_reg    <= `ASC_RESET_VAL;
      mode1_reg             <= `ASC_RESET_VAL;
      channel_select_field  <= 4'h0;
      port_config_reg       <= 5'h00;
      ref_voltage_ctrl_reg  <= `ASC_RESET_VAL;
      peripheral_enable_reg <= `ASC_RESET_VAL;
      status                <= {`ASC_ST_BITS{1'b0}};
      mask                  <= {`ASC_ST_BITS{1'b0}};
    end
    else
    begin
      if (wr && hit(paddr, `ASC_PERIPH_OFF))
        peripheral_enable_reg <= pwdata[7:0];
      if (w_mode)
        converter_mode_reg <= pwdata[7:0];
      else if (trig_go)
        converter_mode_reg[`ASC_MODE_START] <= 1'b1;
      else if (done_ok && single)
        converter_mode_reg[`ASC_MODE_START] <= 1'b0;
      if (w_mode1)
        mode1_reg <= pwdata[7:0];
      if (w_chan)
        channel_select_field <= pwdata[3:0];
      if (w_port)
        port_config_reg <= pwdata[4:0];
      if (wr && gate && hit(paddr, `ASC_REFCTL_OFF))
        ref_voltage_ctrl_reg <= pwdata[7:0];
      if (wr && gate && hit(paddr, `ASC_MASK_OFF))
        mask <= pwdata[`ASC_ST_BITS-1:0];
      // set wins over write-one-to-clear
      status[`ASC_ST_DONE] <= done_ok ||
        (status[`ASC_ST_DONE] && !(wr && hit(paddr, `ASC_STATUS_OFF) && pwdata[0]));
      status[`ASC_ST_ABORT] <= (finishing && ctl_wr) ||
        (status[`ASC_ST_ABORT] && !(wr && hit(paddr, `ASC_STATUS_OFF) && pwdata[1]));
    end
  end

  asc_result_mem #(
    .DW (DW)
  ) u_res (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (done_ok),
    .wr_data (core_data),
    .rd_busy (rd_res),
    .rd_data (result_q)
  );

  // read mux; a disabled gate reads reset values from all but peripheral_enable_reg
  always @*
  begin
    prdata = 32'h0000_0000;
    if (rd)
    begin
      if (hit(paddr, `ASC_PERIPH_OFF))
        prdata = {24'h000000, peripheral_enable_reg};
      else if (gate)
      begin
        if (hit(paddr, `ASC_MODE_OFF))
          prdata = {24'h000000, converter_mode_reg};
        else if (hit(paddr, `ASC_MODE1_OFF))
          prdata = {24'h000000, mode1_reg};
        else if (hit(paddr, `ASC_CHAN_OFF))
          prdata = {28'h0000000, channel_select_field};
        else if (hit(paddr, `ASC_PORTCFG_OFF))
          prdata = {27'h0000000, port_config_reg};
        else if (hit(paddr, `ASC_REFCTL_OFF))
          prdata = {24'h000000, ref_voltage_ctrl_reg};
        else if (hit(paddr, `ASC_RESULT_OFF))
          prdata = {20'h00000, result_q};
        else if (hit(paddr, `ASC_RESULTH_OFF))
          prdata = {24'h000000, result_q[DW-1:DW-8]};
        else if (hit(paddr, `ASC_STATUS_OFF))
          prdata = {30'h00000000, status};
        else if (hit(paddr, `ASC_MASK_OFF))
          prdata = {30'h00000000, mask};
      end
    end
  end
endmodule

//--- verif/asc_core_model.sv
// analog core and timer stand-in for the converter sequencer
`timescale 1ns/1ps
module asc_core_model (
  // converter side
  input  wire        pclk,
  input  wire        core_sample,
  input  wire [3:0]  core_channel,
  output reg  [11:0] core_data,
  // timer side
  output reg         timer_trig
);
  initial timer_trig = 1'b0;
  initial core_data = 12'h000;
  // not held outside a conversion, so a late sample cannot match by chance
  always @(posedge pclk)
    core_data <= core_sample ? 12'h100 + core_channel : ~core_data;
  task fire;
    begin
      @(posedge pclk);
      timer_trig <= 1'b1;
      @(posedge pclk);
      timer_trig <= 1'b0;
    end
  endtask
endmodule

//--- verif/asc_seq_props.sv
// port checker for the converter sequencer
`timescale 1ns/1ps
module asc_seq_props (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        timer_trig,
  input wire [3:0]  core_channel,
  input wire        core_sample,
  input wire        core_enable,
  input wire        conversion_done_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire      wr0 = psel && penable && pwrite && paddr == 12'h000;
  wire      wrx = psel && pwrite;
  reg [7:0] run;
  // a mode or channel write may restart a conversion, so the length count starts over at every write
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      run <= 8'h00;
    else if (!core_sample || wrx || timer_trig)
      run <= 8'h00;
    else if (run != 8'hFF)
      run <= run + 8'h01;
  ready_tied_a: assert property (pready && !pslverr) else $error("pready low or pslverr high");
  rdata_idle_a: assert property (!psel |-> prdata == 32'h0) else $error("prdata not zero");
  chan_hold_a: assert property (core_sample && $past(core_sample) && !$past(wrx)
    && !$past(timer_trig) |-> $stable(core_channel)) else $error("channel moved");
  stop_now_a: assert property (core_sample && wr0 && !pwdata[7] && !timer_trig
    |=> !core_sample) else $error("conversion not stopped");
  irq_cause_a: assert property ($rose(conversion_done_irq)
    |-> $past(core_sample) || $past(psel)) else $error("irq without cause");
  enable_src_a: assert property ($changed(core_enable) |-> $past(wr0)) else $error("enable moved");
  conv_len_a: assert property ($fell(core_sample) && !$past(wrx)
    |-> $past(run) >= 8'h3C) else $error("conversion too short");
  start_src_a: assert property ($rose(core_sample) |-> $past(wr0 || timer_trig)
    || $past(wr0 || timer_trig, 2)) else $error("conversion without start");
endmodule
bind asc_seq asc_seq_props chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .timer_trig(timer_trig), .core_channel(core_channel),
  .core_sample(core_sample), .core_enable(core_enable),
  .conversion_done_irq(conversion_done_irq));

//--- verif/test_adc_sequence_control.sv
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
module test_adc_sequence_control;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire        timer_trig;
  wire [11:0] core_data;
  wire        core_sample;
  wire [3:0]  core_channel;
  wire        core_enable;
  wire        irq;
  reg  [31:0] rd;
  integer     bad_count = 0;
  integer     comparisons = 0;
  integer     cyc;
  always #2.5 pclk = ~pclk;
  asc_seq uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_trig(timer_trig), .core_data(core_data),
    .core_sample(core_sample), .core_channel(core_channel), .core_enable(core_enable),
    .conversion_done_irq(irq));
  asc_core_model model (.pclk(pclk), .core_sample(core_sample),
    .core_channel(core_channel), .core_data(core_data), .timer_trig(timer_trig));
  task chk(input [63:0] nm, input [31:0] exp, input [31:0] got);
    begin
      comparisons = comparisons + 1;
      if (got !== exp)
      begin
        bad_count = bad_count + 1;
        $display("MISMATCH %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      cyc = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && cyc < 50)
      begin
        @(posedge pclk);
        cyc = cyc + 1;
      end
      if (cyc >= 50)
        bad_count = bad_count + 1;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wirq;
    begin
      cyc = 0;
      while (irq !== 1'b1 && cyc < 2000)
      begin
        @(posedge pclk);
        cyc = cyc + 1;
      end
    end
  endtask
  task t_reset;
    begin
      apb(1'b0, 12'h01C, 32'h0);
      chk("status", 32'h0, rd);
      apb(1'b1, 12'h000, 32'h81);
      apb(1'b0, 12'h000, 32'h0);
      chk("gated", 32'h0, rd);
      chk("nosample", 32'h0, {31'h0, core_sample});
      apb(1'b0, 12'h030, 32'h0);
      chk("unmapped", 32'h0, rd);
    end
  endtask
  task t_single;
    begin
      apb(1'b1, 12'h024, 32'h20);
      apb(1'b1, 12'h020, 32'h1);
      apb(1'b1, 12'h008, 32'h3);
      apb(1'b1, 12'h000, 32'h41);
      repeat (200) @(posedge pclk);
      chk("enable", 32'h1, {31'h0, core_enable});
      apb(1'b1, 12'h000, 32'hC1);
      wirq;
      chk("irq", 32'h1, {31'h0, irq});
      apb(1'b0, 12'h014, 32'h0);
      chk("result", 32'h103, rd);
      apb(1'b0, 12'h018, 32'h0);
      chk("resulth", 32'h10, rd);
      apb(1'b0, 12'h000, 32'h0);
      chk("autoclr", 32'h41, rd);
      apb(1'b1, 12'h01C, 32'h1);
      @(posedge pclk);
      chk("irqclr", 32'h0, {31'h0, irq});
    end
  endtask
  task t_abort;
    begin
      apb(1'b1, 12'h010, 32'h3);
      apb(1'b0, 12'h010, 32'h0);
      chk("refctl", 32'h3, rd);
      // the first result after this start is aborted, so it is never used
      apb(1'b1, 12'h000, 32'h81);
      repeat (20) @(posedge pclk);
      apb(1'b1, 12'h008, 32'h5);
      wirq;
      chk("length", 32'h1, {31'h0, cyc >= 62 && cyc <= 67});
      apb(1'b0, 12'h014, 32'h0);
      chk("newchan", 32'h105, rd);
      apb(1'b1, 12'h000, 32'h01);
      @(posedge pclk);
      chk("stopped", 32'h0, {31'h0, core_sample});
      apb(1'b1, 12'h010, 32'h0);
      apb(1'b1, 12'h01C, 32'h3);
    end
  endtask
  task t_timer;
    begin
      apb(1'b1, 12'h004, 32'h80);
      apb(1'b1, 12'h000, 32'h41);
      model.fire;
      repeat (2) @(posedge pclk);
      chk("trigger", 32'h1, {31'h0, core_sample});
      apb(1'b1, 12'h008, 32'h7);
      chk("chanheld", 32'h5, {28'h0, core_channel});
      wirq;
      apb(1'b0, 12'h014, 32'h0);
      chk("oldchan", 32'h105, rd);
      apb(1'b1, 12'h01C, 32'h1);
      apb(1'b1, 12'h020, 32'h0);
      model.fire;
      wirq;
      chk("masked", 32'h0, {31'h0, irq});
      apb(1'b0, 12'h01C, 32'h0);
      chk("sticky", 32'h1, rd);
      apb(1'b0, 12'h014, 32'h0);
      chk("nextchan", 32'h107, rd);
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b1, 12'h004, 32'h0);
      apb(1'b1, 12'h024, 32'h0);
      apb(1'b0, 12'h014, 32'h0);
      chk("gateoff", 32'h0, rd);
    end
  endtask
  task report_and_stop;
    begin
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_single;
    t_abort;
    t_timer;
    report_and_stop;
  end
  initial
  begin
    #100000;
    bad_count = bad_count + 1;
    report_and_stop;
  end
endmodule
